// File: design/gaf_pkg.sv
// package for the gpio alternate-function block: timing, field positions, reset values
// assumes a single 10 MHz device clock
package gaf_pkg;
   // ==========================================
   // clock and time base
   // ==========================================
   localparam int CLK_HZ = 10000000; // device clock rate
   localparam int DEBOUNCE_US = 1000; // pulses of this width or less are rejected
   // cycles a level must stay stable before it passes (strictly longer than 1 ms)
   localparam int DEBOUNCE_CYC = (CLK_HZ / 1000000) * DEBOUNCE_US + 1;
   localparam int HALF_SEC_MS = 500; // half period of the 1 Hz led wave
   localparam int HALF_SEC_CYC = (CLK_HZ / 1000) * HALF_SEC_MS;
   localparam int MINUTE_HALF_SECS = 120; // half seconds in one minute
   // ==========================================
   // register fields
   // ==========================================
   localparam int CTLA_LED_ON_TIMEOUT_BIT = 3; // watchdog_control_a: led on time-out
   localparam int CTLB_TIMEOUT_BIT = 0; // watchdog_control_b: time-out status
   localparam int CTLB_LED_FORCE_BIT = 1; // watchdog_control_b: led always toggles
   localparam logic [7:0] CTLB_RESET = 8'h00; // watchdog_control_b after reset
   localparam logic [7:0] COUNT_RESET = 8'h00; // watchdog_count after reset
   localparam logic [15:0] WDT_CTLB_OFFSET = 16'h0001; // above second group base
   localparam int STEER_CHANNELS = 3; // steered interrupt pins
   localparam int IRQ_SEL_W = 4; // irq select field width
   localparam int IRQ_LINES = 16; // host interrupt channels
endpackage

// File: design/gaf_gpio_alt.sv
// gpio alternate functions: interrupt steering, watchdog, power led, address decoders
// assumes host bus inputs synchronous to ref_clk; configuration arrives as plain ports
//
// Summary of operation
// - every alternate function passes pin polarity control
// - steering pins routed to selected irq channel
// - each steered channel debounces pulses up to 1ms
// - watchdog down counter decrements once per minute
// - nonzero write, or kbd/mouse irq edge while count nonzero, reloads
// - count-down to zero sets time-out flag bit 0; a zero write does not
// - watchdog irq asserted only when enabled
// - led toggles after time-out if control_a bit3
// - control_b host accessible at group base plus one
// - led toggles at 1 Hz, 50 percent duty
// - control_b bit1 forces toggle, else time-out gated
// - steady led level set by polarity bit
// - decoders compare base, active only when aen low
// - decoder outputs active low, polarity invertible
// - write strobe also gated by iow low
`timescale 1ns/1ps
module gaf_gpio_alt #(
   parameter int HALF_SEC_CYCLES = gaf_pkg::HALF_SEC_CYC, // shortened in simulation
   parameter int DEBOUNCE_CYCLES = gaf_pkg::DEBOUNCE_CYC // shortened in simulation
) (
   input wire logic ref_clk, // device clock
   input wire logic reset, // asynchronous, active high
   // interrupt steering
   input wire logic [gaf_pkg::STEER_CHANNELS-1:0] steer_pin_in, // a, b, c pin levels
   input wire logic [gaf_pkg::STEER_CHANNELS-1:0] steer_polarity, // 1 inverts
   input wire logic [gaf_pkg::STEER_CHANNELS*gaf_pkg::IRQ_SEL_W-1:0] irq_select_config,
   output logic [gaf_pkg::IRQ_LINES-1:0] steer_irq, // host irq lines, 0 selects none
   // watchdog
   input wire logic count_wr, // write strobe for watchdog_count
   input wire logic [7:0] count_wdata, // minutes to load
   input wire logic kbd_irq, // keyboard interrupt level
   input wire logic mouse_irq, // mouse interrupt level
   input wire logic [7:0] watchdog_control_a, // configuration byte
   input wire logic watchdog_irq_enable, // enable from watchdog_irq_config
   input wire logic watchdog_out_polarity, // polarity of watchdog output pin
   output logic watchdog_out, // watchdog interrupt at the pin
   output logic [7:0] watchdog_count_rd, // live counter value
   // power led
   input wire logic led_polarity, // polarity of the led pin
   output logic led_out, // power led pin level
   // host bus
   input wire logic [15:0] host_addr, // isa address
   input wire logic aen, // address enable, decoders live while low
   input wire logic iow_n, // isa write strobe, active low
   input wire logic ior_n, // isa read strobe, active low
   input wire logic [7:0] host_wdata, // isa write data
   output logic [7:0] host_rdata, // read data for watchdog_control_b
   output logic host_rdata_oe, // high while the block drives the data bus
   input wire logic [15:0] second_group_base, // i/o base of the second group
   input wire logic [15:0] decoder_base_a, // base for decoder pin a
   input wire logic [15:0] decoder_base_b, // base for decoder pin b
   input wire logic [15:0] decoder_base_c, // base for decoder pin c
   input wire logic [15:0] strobe_base, // base for the write strobe
   input wire logic [3:0] decoder_polarity, // a, b, c, strobe; 1 inverts
   output logic [2:0] decoder_out, // decoder pins a, b, c
   output logic write_strobe_out, // write strobe pin
   output logic [7:0] watchdog_control_b // control_b contents
);
   // ==========================================
   // shared helpers
   // ==========================================
   // qualified address match, used by every decoder
   function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] b,
                                     input logic en_n);
      addr_hit = (a == b) && !en_n;
   endfunction

   // any clean steered level whose select names this host line; line 0 means unrouted
   function automatic logic steer_hit(
      input logic [gaf_pkg::STEER_CHANNELS*gaf_pkg::IRQ_SEL_W-1:0] sel,
      input logic [gaf_pkg::STEER_CHANNELS-1:0] clean,
      input int chan);
      steer_hit = 1'b0;
      for (int i = 0; i < gaf_pkg::STEER_CHANNELS; i++)
      begin
         if (chan != 0 && sel[i*gaf_pkg::IRQ_SEL_W +: gaf_pkg::IRQ_SEL_W] == 4'(chan) && clean[i])
         begin
            steer_hit = 1'b1;
         end
      end
   endfunction

   // ==========================================
   // time base prescaler
   // ==========================================
   logic [31:0] half_cnt_reg; // cycles within a half second
   logic half_tick; // one cycle pulse every half second
   logic [6:0] min_cnt_reg; // half seconds within a minute
   logic minute_tick; // one cycle pulse every minute
   logic led_phase_reg; // free running 1 Hz square wave

   assign half_tick = (half_cnt_reg == 32'(HALF_SEC_CYCLES - 1));
   assign minute_tick = half_tick && (min_cnt_reg == 7'(gaf_pkg::MINUTE_HALF_SECS - 1));

   // half second divider from the free-running clock
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         half_cnt_reg <= 32'h00000000;
      end
      else if (half_tick)
      begin
         half_cnt_reg <= 32'h00000000;
      end
      else
      begin
         half_cnt_reg <= half_cnt_reg + 32'h00000001;
      end
   end

   // minute divider and the 1 Hz phase share the half second tick
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         min_cnt_reg <= 7'h00;
         led_phase_reg <= 1'b0;
      end
      else if (half_tick)
      begin
         // equal half periods give the 50 percent duty
         led_phase_reg <= !led_phase_reg;
         min_cnt_reg <= minute_tick ? 7'h00 : min_cnt_reg + 7'h01;
      end
   end

   // ==========================================
   // interrupt steering with debounce
   // ==========================================
   logic [gaf_pkg::STEER_CHANNELS-1:0] steer_level; // pin after polarity
   logic [gaf_pkg::STEER_CHANNELS-1:0] steer_clean_reg; // debounced level
   logic [31:0] deb_cnt_reg [gaf_pkg::STEER_CHANNELS]; // stability counters

   assign steer_level = steer_pin_in ^ steer_polarity;

   // a change must persist past 1 ms before it is accepted; shorter pulses vanish
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         steer_clean_reg <= '0;
         for (int i = 0; i < gaf_pkg::STEER_CHANNELS; i++)
         begin
            deb_cnt_reg[i] <= 32'h00000000;
         end
      end
      else
      begin
         for (int i = 0; i < gaf_pkg::STEER_CHANNELS; i++)
         begin
            if (steer_level[i] == steer_clean_reg[i])
            begin
               deb_cnt_reg[i] <= 32'h00000000;
            end
            else if (deb_cnt_reg[i] == 32'(DEBOUNCE_CYCLES - 1))
            begin
               steer_clean_reg[i] <= steer_level[i];
               deb_cnt_reg[i] <= 32'h00000000;
            end
            else
            begin
               deb_cnt_reg[i] <= deb_cnt_reg[i] + 32'h00000001;
            end
         end
      end
   end

   // route each clean level to its chosen channel; select 0 leaves it unrouted
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         steer_irq <= '0;
      end
      else
      begin
         for (int l = 0; l < gaf_pkg::IRQ_LINES; l++)
         begin
            steer_irq[l] <= steer_hit(irq_select_config, steer_clean_reg, l);
         end
      end
   end

   // ==========================================
   // watchdog counter
   // ==========================================
   logic [7:0] count_reg; // remaining minutes
   logic kbd_d_reg; // previous keyboard level
   logic mouse_d_reg; // previous mouse level
   logic [7:0] reload_val_reg; // last non-zero load value
   logic kick; // keyboard or mouse rising edge
   logic ctlb_wr; // host write to watchdog_control_b
   logic ctlb_rd; // host read of watchdog_control_b
   logic timeout_event; // counter steps 1 -> 0

   assign kick = (kbd_irq && !kbd_d_reg) || (mouse_irq && !mouse_d_reg);
   // a reload in the cycle of the last minute tick wins, so no false time-out
   assign timeout_event = minute_tick && (count_reg == 8'h01) && !count_wr && !kick;
   assign ctlb_wr = addr_hit(host_addr, second_group_base + gaf_pkg::WDT_CTLB_OFFSET, aen)
                    && !iow_n;
   assign ctlb_rd = addr_hit(host_addr, second_group_base + gaf_pkg::WDT_CTLB_OFFSET, aen)
                    && !ior_n;

   // interrupt edge memory for the reload kick
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         kbd_d_reg <= 1'b0;
         mouse_d_reg <= 1'b0;
      end
      else
      begin
         kbd_d_reg <= kbd_irq;
         mouse_d_reg <= mouse_irq;
      end
   end

   // load, reload and count down; a zero write stops the timer
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         count_reg <= gaf_pkg::COUNT_RESET;
         reload_val_reg <= gaf_pkg::COUNT_RESET;
      end
      else if (count_wr)
      begin
         count_reg <= count_wdata;
         if (count_wdata != 8'h00)
         begin
            reload_val_reg <= count_wdata;
         end
      end
      else if (kick && count_reg != 8'h00)
      begin
         count_reg <= reload_val_reg;
      end
      else if (minute_tick && count_reg != 8'h00)
      begin
         count_reg <= count_reg - 8'h01;
      end
   end

   // control_b: time-out flag set wins over a host write in the same cycle
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         watchdog_control_b <= gaf_pkg::CTLB_RESET;
      end
      else
      begin
         if (ctlb_wr)
         begin
            watchdog_control_b <= host_wdata;
         end
         if (timeout_event)
         begin
            watchdog_control_b[gaf_pkg::CTLB_TIMEOUT_BIT] <= 1'b1;
         end
      end
   end

   // ==========================================
   // registered outputs
   // ==========================================
   logic led_toggle; // led currently toggling
   logic timed_out; // time-out flag

   assign timed_out = watchdog_control_b[gaf_pkg::CTLB_TIMEOUT_BIT];
   assign led_toggle = watchdog_control_b[gaf_pkg::CTLB_LED_FORCE_BIT] ||
      (watchdog_control_a[gaf_pkg::CTLA_LED_ON_TIMEOUT_BIT] && timed_out);

   // watchdog pin, led pin and readback
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         watchdog_out <= 1'b0;
         led_out <= 1'b0;
         watchdog_count_rd <= 8'h00;
         host_rdata <= 8'h00;
         host_rdata_oe <= 1'b0;
      end
      else
      begin
         watchdog_out <= (timed_out && watchdog_irq_enable) ^ watchdog_out_polarity;
         // steady level is the polarity bit alone
         led_out <= (led_toggle & led_phase_reg) ^ led_polarity;
         watchdog_count_rd <= count_reg;
         host_rdata <= ctlb_rd ? watchdog_control_b : 8'h00;
         host_rdata_oe <= ctlb_rd;
      end
   end

   // decoders: active low when polarity 0; one cycle of latency from the bus
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         decoder_out <= 3'h7;
         write_strobe_out <= 1'b1;
      end
      else
      begin
         decoder_out[0] <= !addr_hit(host_addr, decoder_base_a, aen)
                           ^ decoder_polarity[0];
         decoder_out[1] <= !addr_hit(host_addr, decoder_base_b, aen)
                           ^ decoder_polarity[1];
         decoder_out[2] <= !addr_hit(host_addr, decoder_base_c, aen)
                           ^ decoder_polarity[2];
         write_strobe_out <= !(addr_hit(host_addr, strobe_base, aen) && !iow_n)
                             ^ decoder_polarity[3];
      end
   end
endmodule // gaf_gpio_alt

// File: dv/gaf_alt_props.sv
// checker for gaf_gpio_alt: decoders, strobe, watchdog flag and output, led
// assumes binding to gaf_gpio_alt; sees its ports only
`timescale 1ns/1ps
module gaf_alt_props (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic count_wr,
   input wire logic [7:0] watchdog_control_a,
   input wire logic watchdog_irq_enable,
   input wire logic watchdog_out_polarity,
   input wire logic watchdog_out,
   input wire logic [7:0] watchdog_count_rd,
   input wire logic led_polarity,
   input wire logic led_out,
   input wire logic [15:0] host_addr,
   input wire logic aen,
   input wire logic iow_n,
   input wire logic [15:0] second_group_base,
   input wire logic [15:0] decoder_base_a,
   input wire logic [15:0] strobe_base,
   input wire logic [3:0] decoder_polarity,
   input wire logic [2:0] decoder_out,
   input wire logic write_strobe_out,
   input wire logic [7:0] watchdog_control_b
);
   // ==========================================
   // assertions
   // ==========================================
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   logic ctlb_wr; // host write to control_b, the only way to clear the flag
   assign ctlb_wr = !iow_n && !aen && host_addr == second_group_base + 16'h0001;
   a_flag_sticky: assert property (watchdog_control_b[0] && !ctlb_wr |=>
      watchdog_control_b[0]) else $error("time-out flag dropped without a host write");
   a_wdt_out_gate: assert property (!$past(reset) |-> watchdog_out ==
      ($past(watchdog_control_b[0] & watchdog_irq_enable) ^ $past(watchdog_out_polarity)))
      else $error("watchdog output not flag and enable at pin polarity");
   a_dec_hit: assert property (!aen && host_addr == decoder_base_a |=>
      decoder_out[0] == $past(decoder_polarity[0])) else $error("decoder a missed");
   a_dec_idle: assert property (aen |=>
      decoder_out == ~$past(decoder_polarity[2:0])) else $error("decoder active with aen high");
   a_strobe_hit: assert property (!aen && !iow_n && host_addr == strobe_base |=>
      write_strobe_out == $past(decoder_polarity[3])) else $error("strobe missed");
   a_strobe_idle: assert property (iow_n |=>
      write_strobe_out == !$past(decoder_polarity[3])) else $error("strobe active without write");
   a_count_hold: assert property (watchdog_count_rd == 8'h00 && !$past(count_wr) |=>
      watchdog_count_rd == 8'h00) else $error("counter left zero");
   a_zero_sets_flag: assert property ($past(watchdog_count_rd) == 8'h01 &&
      watchdog_count_rd == 8'h00 && !$past(count_wr) && !$past(count_wr, 2) |->
      ##[0:2] watchdog_control_b[0]) else $error("zero count without flag");
   a_led_steady: assert property ((!watchdog_control_b[1] && !watchdog_control_a[3] &&
      $stable(led_polarity)) [*3] |-> $stable(led_out)) else $error("led moved");
   c_flag: cover property ($rose(watchdog_control_b[0]));
   c_strobe: cover property (!write_strobe_out && !decoder_polarity[3]);
   c_led: cover property (watchdog_control_b[1] && $changed(led_out));
endmodule // gaf_alt_props
bind gaf_gpio_alt gaf_alt_props chk_i (.ref_clk, .reset, .count_wr, .watchdog_control_a,
   .watchdog_irq_enable, .watchdog_out_polarity, .watchdog_out, .watchdog_count_rd,
   .led_polarity, .led_out, .host_addr, .aen, .iow_n, .second_group_base, .decoder_base_a,
   .strobe_base, .decoder_polarity, .decoder_out, .write_strobe_out, .watchdog_control_b);

// File: dv/gaf_isa_host.sv
// isa host model: one bus cycle at a time on address, aen and strobes
// assumes the block registers its answers on ref_clk
`timescale 1ns/1ps
module gaf_isa_host (
   input wire logic ref_clk,
   input wire logic [7:0] host_rdata,
   output logic [15:0] host_addr,
   output logic aen,
   output logic iow_n,
   output logic ior_n,
   output logic [7:0] host_wdata
);
   // idle bus: aen high keeps every decoder quiet
   initial
   begin
      {host_addr, aen, iow_n, ior_n, host_wdata} = {16'hFFFF, 3'h7, 8'hFF};
   end
   // cycle held over two edges; answer taken at the releasing edge
   task automatic io(input logic [15:0] a, input logic en, input logic wr, input logic rd,
                     input logic [7:0] d, output logic [7:0] q);
      @(posedge ref_clk);
      #1;
      {host_addr, aen, iow_n, ior_n, host_wdata} = {a, en, ~wr, ~rd, d};
      repeat (2) @(posedge ref_clk);
      #1;
      q = host_rdata;
      // released lines must not keep showing the last address or data
      {host_addr, aen, iow_n, ior_n, host_wdata} = {~a, 3'h7, ~d};
   endtask
endmodule // gaf_isa_host

// File: dv/gpio_alternate_functions_tb.sv
// testbench for gaf_gpio_alt: decoders, strobe, control_b, led, watchdog, steering
// assumes gaf_isa_host on the bus and shortened time bases
`timescale 1ns/1ps
module gpio_alternate_functions_tb;
   localparam int HALF = 4; // shortened half second
   localparam int MINUTE = 120 * HALF; // cycles per watchdog minute
   logic ref_clk = 1'b0, reset = 1'b1, count_wr = 1'b0, kbd_irq = 1'b0, mouse_irq = 1'b0;
   logic [2:0] steer_pin_in = 3'h0, steer_polarity = 3'h2; // pin b inverted
   logic [11:0] irq_select_config = 12'h065; // a to line 5, b to line 6, c nowhere
   logic [7:0] count_wdata = 8'h00, watchdog_control_a = 8'h00;
   logic watchdog_irq_enable = 1'b0, watchdog_out_polarity = 1'b0, led_polarity = 1'b0;
   logic [15:0] second_group_base = 16'h0340, strobe_base = 16'h0330;
   logic [15:0] decoder_base_a = 16'h0300, decoder_base_b = 16'h0310, decoder_base_c = 16'h0320;
   logic [3:0] decoder_polarity = 4'h0;
   logic [15:0] steer_irq, host_addr;
   logic [7:0] watchdog_count_rd, host_wdata, host_rdata, watchdog_control_b, q;
   logic watchdog_out, led_out, aen, iow_n, ior_n, host_rdata_oe, write_strobe_out, l;
   logic [2:0] decoder_out;
   int n_fail = 0, n_tests = 0, cyc = 0, n;
   gaf_gpio_alt #(.HALF_SEC_CYCLES(HALF), .DEBOUNCE_CYCLES(3)) dut (
      .ref_clk, .reset, .steer_pin_in, .steer_polarity, .irq_select_config, .steer_irq,
      .count_wr, .count_wdata, .kbd_irq, .mouse_irq, .watchdog_control_a,
      .watchdog_irq_enable, .watchdog_out_polarity, .watchdog_out, .watchdog_count_rd,
      .led_polarity, .led_out, .host_addr, .aen, .iow_n, .ior_n, .host_wdata, .host_rdata,
      .host_rdata_oe, .second_group_base, .decoder_base_a, .decoder_base_b, .decoder_base_c,
      .strobe_base, .decoder_polarity, .decoder_out, .write_strobe_out, .watchdog_control_b);
   gaf_isa_host host (.ref_clk, .host_rdata, .host_addr, .aen, .iow_n, .ior_n, .host_wdata);
   initial forever #50 ref_clk = ~ref_clk;
   // hang guard: the whole run needs about 2900 cycles
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         stop_test();
      end
   end
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   // cycles until the led next changes, bounded
   task automatic led_half(output int k);
      l = led_out;
      for (k = 0; led_out === l && k < 50; k++) tick(1);
   endtask
   task automatic wait_cnt(input logic [7:0] v, output int k);
      for (k = 0; watchdog_count_rd !== v && k < 2000; k++) tick(1);
   endtask
   task automatic load(input logic [7:0] v);
      {count_wdata, count_wr} = {v, 1'b1};
      tick(1);
      count_wr = 1'b0;
      tick(1);
   endtask
   task automatic t_decode();
      for (int p = 0; p < 2; p++)
      begin
         decoder_polarity = {4{p[0]}};
         host.io(16'h0300, 1'b1, 1'b0, 1'b0, 8'h00, q);
         chk("dec_aen", 16'(decoder_out), 16'({3{~p[0]}}));
         for (int i = 0; i < 3; i++)
         begin
            host.io(16'h0300 + 16'(i * 16), 1'b0, 1'b0, 1'b0, 8'h00, q);
            // braces keep the expected pattern at the three pin bits before widening
            chk("dec_hit", 16'(decoder_out), 16'({~(3'h1 << i) ^ {3{p[0]}}}));
         end
         host.io(16'h0330, 1'b0, 1'b1, 1'b0, 8'h5A, q);
         chk("strobe_hit", 16'(write_strobe_out), 16'(p[0]));
         host.io(16'h0330, 1'b0, 1'b0, 1'b0, 8'h00, q);
         chk("strobe_no_iow", 16'(write_strobe_out), 16'({~p[0]}));
      end
      decoder_polarity = 4'h0;
      $display("end decode");
   endtask
   task automatic t_ctlb();
      host.io(16'h0340, 1'b0, 1'b1, 1'b0, 8'h02, q);
      chk("ctlb_miss", 16'(watchdog_control_b), 16'h0000);
      host.io(16'h0341, 1'b0, 1'b1, 1'b0, 8'h02, q);
      host.io(16'h0341, 1'b0, 1'b0, 1'b1, 8'h00, q);
      chk("ctlb_read", 16'({host_rdata_oe, q}), 16'h0102);
      led_half(n);
      led_half(n);
      chk("led_half_a", 16'(n), 16'(HALF));
      led_half(n);
      chk("led_half_b", 16'(n), 16'(HALF));
      host.io(16'h0341, 1'b0, 1'b1, 1'b0, 8'h00, q);
      tick(3);
      l = led_out;
      tick(20);
      chk("led_steady", 16'(led_out), 16'(l));
      led_polarity = 1'b1;
      tick(3);
      chk("led_pol", 16'(led_out), 16'({~l}));
      led_polarity = 1'b0;
      $display("end ctlb");
   endtask
   task automatic t_steer();
      chk("steer_pol", steer_irq, 16'h0040);
      steer_pin_in = 3'h1;
      tick(2);
      steer_pin_in = 3'h0;
      tick(8);
      chk("steer_short", steer_irq, 16'h0040);
      steer_pin_in = 3'h1;
      tick(10);
      chk("steer_long", steer_irq, 16'h0060);
      steer_pin_in = 3'h4;
      tick(10);
      chk("steer_none", steer_irq, 16'h0040);
      $display("end steer");
   endtask
   task automatic t_wdog();
      {watchdog_control_a, watchdog_irq_enable} = {8'h08, 1'b1};
      load(8'hFF);
      chk("count_load", 16'(watchdog_count_rd), 16'h00FF);
      load(8'h01);
      for (n = 0; watchdog_control_b[0] !== 1'b1 && n < 1000; n++) tick(1);
      tick(1);
      chk("timeout", 16'({watchdog_control_b[0], watchdog_count_rd}), 16'h0100);
      chk("wdt_out", 16'(watchdog_out), 16'h0001);
      led_half(n);
      led_half(n);
      chk("led_timeout", 16'(n), 16'(HALF));
      watchdog_irq_enable = 1'b0;
      tick(2);
      chk("wdt_masked", 16'(watchdog_out), 16'h0000);
      {watchdog_out_polarity, watchdog_irq_enable} = 2'h3;
      tick(2);
      chk("wdt_inverted", 16'(watchdog_out), 16'h0000);
      kbd_irq = 1'b1;
      tick(MINUTE + 10);
      chk("zero_hold", 16'({watchdog_control_b[0], watchdog_count_rd}), 16'h0100);
      {kbd_irq, watchdog_out_polarity} = 2'h0;
      host.io(16'h0341, 1'b0, 1'b1, 1'b0, 8'h00, q);
      chk("flag_clear", 16'(watchdog_control_b), 16'h0000);
      load(8'h03);
      wait_cnt(8'h02, n);
      wait_cnt(8'h01, n);
      chk("minute", 16'(n), 16'(MINUTE));
      kbd_irq = 1'b1;
      tick(3);
      chk("kbd_kick", 16'(watchdog_count_rd), 16'h0003);
      wait_cnt(8'h02, n);
      mouse_irq = 1'b1;
      tick(3);
      chk("mouse_kick", 16'(watchdog_count_rd), 16'h0003);
      {kbd_irq, mouse_irq} = 2'h0;
      // a zero write stops the timer; a kick must not revive it nor raise the flag
      load(8'h00);
      kbd_irq = 1'b1;
      tick(MINUTE + 10);
      chk("zero_stop", 16'({watchdog_control_b[0], watchdog_count_rd}), 16'h0000);
      kbd_irq = 1'b0;
      $display("end wdog");
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      tick(8);
      reset = 1'b0;
      chk("reset_pins", 16'({decoder_out, write_strobe_out}), 16'h000F);
      t_decode();
      t_ctlb();
      t_steer();
      t_wdog();
      stop_test();
   end
endmodule // gpio_alternate_functions_tb
